// *** hw/eeis_pkg.sv ***
// Package of constants and mode decoding for the encoder emulation index block
// Summary of operation
// - Once-per-revolution modes pulse index each time in-revolution position reaches the offset.
// - Offset is a 16-bit fraction of a revolution; 32768 means 180 degrees.
// - Absolute modes pulse index only at position turn number plus offset.
// - Turn number is an unsigned 32-bit revolution count selecting the index revolution.
// - Pass-through modes copy each physical index pulse, ignoring offset and turn.
// - Mode zero makes the connector a secondary feedback input; type set separately.
// - Mode one drives A/B with per-revolution index; mode two with absolute index.
// - Modes three to five are legacy inputs: A/B, step/direction, up/down.
// - Modes six and seven drive step/direction with per-revolution or absolute index.
// - Modes eight and nine drive up/down pulses with per-revolution or absolute index.
// - Mode ten releases the lines as general-purpose I/O; no emulation.
// - Mode eleven makes the connector a tertiary feedback input; type set separately.
// - Modes twelve to fourteen drive A/B, step/direction, up/down with passed-through index.
// - Mode accepts values zero to fourteen and is zero after reset.
package eeis_pkg;

   // ----------------------------------------
   // Widths and register map
   // ----------------------------------------
   localparam int EEIS_AW = 8;
   localparam int EEIS_DW = 32;
   localparam int EEIS_REV_W = 16;
   localparam int EEIS_TURN_W = 32;
   localparam int EEIS_POS_W = EEIS_TURN_W + EEIS_REV_W;
   localparam logic [7:0] EEIS_OFF_MODE = 8'h00;
   localparam logic [7:0] EEIS_OFF_ZOFFSET = 8'h04;
   localparam logic [7:0] EEIS_OFF_MTURN = 8'h08;
   localparam logic [7:0] EEIS_OFF_FBTYPE = 8'h0c;
   localparam logic [7:0] EEIS_OFF_GPIO = 8'h10;
   localparam logic [7:0] EEIS_OFF_STATUS = 8'h14;
   localparam logic [7:0] EEIS_OFF_EMUPOS = 8'h18;
   localparam int EEIS_FB_SEC_LSB = 0;
   localparam int EEIS_FB_TER_LSB = 4;
   localparam int EEIS_GPIO_OUT_LSB = 0;
   localparam int EEIS_GPIO_DRV_LSB = 4;
   localparam int EEIS_ST_PINS_LSB = 0;
   localparam int EEIS_ST_BUSY_BIT = 3;
   localparam int EEIS_ST_ZCNT_LSB = 16;
   localparam logic [3:0] EEIS_MODE_RST = 4'h0;
   localparam logic [15:0] EEIS_ZOFFSET_RST = 16'h0000;
   localparam logic [31:0] EEIS_MTURN_RST = 32'h0000_0000;

   // ----------------------------------------
   // Modes
   // ----------------------------------------
   localparam logic [3:0] EEIS_MODE_MAX = 4'he;
   localparam logic [3:0] EEIS_MODE_GPIO = 4'ha;

   typedef enum logic [1:0] {EEIS_FMT_QUAD, EEIS_FMT_STEP, EEIS_FMT_UPDN} eeis_fmt_e;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int EEIS_CLK_PS = 8000;
   localparam int EEIS_STEP_MIN_PS = 16000;
   localparam int EEIS_STEP_CYC = (EEIS_STEP_MIN_PS + EEIS_CLK_PS - 1) / EEIS_CLK_PS;

   function automatic logic eeis_rev_mode(input logic [3:0] m);
      return (m == 4'h1) || (m == 4'h6) || (m == 4'h8);
   endfunction

   function automatic logic eeis_abs_mode(input logic [3:0] m);
      return (m == 4'h2) || (m == 4'h7) || (m == 4'h9);
   endfunction

   function automatic logic eeis_pass_mode(input logic [3:0] m);
      return (m == 4'hc) || (m == 4'hd) || (m == 4'he);
   endfunction

   function automatic logic eeis_out_mode(input logic [3:0] m);
      return eeis_rev_mode(m) || eeis_abs_mode(m) || eeis_pass_mode(m);
   endfunction

   function automatic eeis_fmt_e eeis_fmt(input logic [3:0] m);
      if ((m == 4'h6) || (m == 4'h7) || (m == 4'hd)) begin
         return EEIS_FMT_STEP;
      end else if ((m == 4'h8) || (m == 4'h9) || (m == 4'he)) begin
         return EEIS_FMT_UPDN;
      end
      return EEIS_FMT_QUAD;
   endfunction

endpackage

// *** hw/eeis_index_detect.sv ***
// Index crossing detector between two successive position samples
`timescale 1ns/1ps
module eeis_index_detect (
   input wire logic [eeis_pkg::EEIS_POS_W-1:0] prev_pos,
   input wire logic [eeis_pkg::EEIS_POS_W-1:0] cur_pos,
   input wire logic [eeis_pkg::EEIS_REV_W-1:0] offset,
   input wire logic [eeis_pkg::EEIS_TURN_W-1:0] turn,
   output logic rev_hit,
   output logic abs_hit
);
   import eeis_pkg::*;

   wire logic fwd = cur_pos > prev_pos;
   wire logic bwd = cur_pos < prev_pos;
   wire logic [EEIS_POS_W-1:0] up_dist = cur_pos - prev_pos;
   wire logic [EEIS_POS_W-1:0] dn_dist = prev_pos - cur_pos;
   // Distance to the next offset in the direction of travel, modulo one turn
   wire logic [EEIS_REV_W-1:0] up_gap = offset - prev_pos[EEIS_REV_W-1:0];
   wire logic [EEIS_REV_W-1:0] dn_gap = prev_pos[EEIS_REV_W-1:0] - offset;
   wire logic [EEIS_POS_W-1:0] target = {turn, offset};

   // Target in (prev, cur] going up, or in [cur, prev) going down
   // Limitation: a jump of a full turn or more between samples may miss one
   assign rev_hit = (fwd && (up_gap != '0) && ({32'h0, up_gap} <= up_dist)) ||
                    (bwd && (dn_gap != '0) && ({32'h0, dn_gap} <= dn_dist));
   assign abs_hit = (fwd && (prev_pos < target) && (target <= cur_pos)) ||
                    (bwd && (cur_pos <= target) && (target < prev_pos));
endmodule

// *** hw/eeis_top.sv ***
// Emulated encoder port: mode select, pulse emulation and index placement
`timescale 1ns/1ps
module eeis_top (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [eeis_pkg::EEIS_AW-1:0] reg_addr,
   input wire logic [eeis_pkg::EEIS_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [eeis_pkg::EEIS_DW-1:0] reg_rdata,
   input wire logic [eeis_pkg::EEIS_POS_W-1:0] primary_pos,
   input wire logic primary_pos_valid,
   input wire logic phys_index,
   input wire logic [2:0] pin_in,
   output logic [2:0] pin_out,
   output logic [2:0] pin_oe_n,
   output logic [3:0] secondary_feedback_type,
   output logic [3:0] tertiary_feedback_type,
   output logic encoder_input_active,
   output logic tertiary_input_active
);
   import eeis_pkg::*;

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   logic [3:0] mode_q;
   logic [15:0] zoffset_q;
   logic [31:0] mturn_q;
   logic [3:0] sec_type_q;
   logic [3:0] ter_type_q;
   logic [2:0] gpio_out_q;
   logic [2:0] gpio_drv_q;
   logic [31:0] rdata_q;
   logic [15:0] zcnt_q;

   wire logic sel_mode = reg_addr == EEIS_OFF_MODE;
   wire logic sel_zoff = reg_addr == EEIS_OFF_ZOFFSET;
   wire logic sel_turn = reg_addr == EEIS_OFF_MTURN;
   wire logic sel_fb = reg_addr == EEIS_OFF_FBTYPE;
   wire logic sel_gpio = reg_addr == EEIS_OFF_GPIO;
   wire logic sel_st = reg_addr == EEIS_OFF_STATUS;
   wire logic sel_pos = reg_addr == EEIS_OFF_EMUPOS;
   // Out-of-range modes are dropped so the port never enters an undefined mode
   wire logic mode_ok = reg_wdata <= {28'h0, EEIS_MODE_MAX};

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         mode_q <= EEIS_MODE_RST;
      end else if (reg_wr && sel_mode && mode_ok) begin
         mode_q <= reg_wdata[3:0];
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         zoffset_q <= EEIS_ZOFFSET_RST;
         mturn_q <= EEIS_MTURN_RST;
      end else begin
         if (reg_wr && sel_zoff) begin
            zoffset_q <= reg_wdata[15:0];
         end
         if (reg_wr && sel_turn) begin
            mturn_q <= reg_wdata;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sec_type_q <= 4'h0;
         ter_type_q <= 4'h0;
         gpio_out_q <= 3'h0;
         gpio_drv_q <= 3'h0;
      end else begin
         if (reg_wr && sel_fb) begin
            sec_type_q <= reg_wdata[EEIS_FB_SEC_LSB +: 4];
            ter_type_q <= reg_wdata[EEIS_FB_TER_LSB +: 4];
         end
         if (reg_wr && sel_gpio) begin
            gpio_out_q <= reg_wdata[EEIS_GPIO_OUT_LSB +: 3];
            gpio_drv_q <= reg_wdata[EEIS_GPIO_DRV_LSB +: 3];
         end
      end
   end

   // ----------------------------------------
   // Mode decoding
   // ----------------------------------------
   wire logic is_rev = eeis_rev_mode(mode_q);
   wire logic is_abs = eeis_abs_mode(mode_q);
   wire logic is_pass = eeis_pass_mode(mode_q);
   wire logic is_out = eeis_out_mode(mode_q);
   wire eeis_fmt_e fmt = eeis_fmt(mode_q);
   wire logic is_gpio = mode_q == EEIS_MODE_GPIO;

   // Modes 0 and 3..5 listen on the port; 11 is the tertiary input
   assign encoder_input_active = (mode_q == 4'h0) || ((mode_q >= 4'h3) && (mode_q <= 4'h5));
   assign tertiary_input_active = mode_q == 4'hb;
   assign secondary_feedback_type = sec_type_q;
   assign tertiary_feedback_type = ter_type_q;

   // ----------------------------------------
   // Position follower and pulse generation
   // ----------------------------------------
   logic [EEIS_POS_W-1:0] target_q;
   logic [EEIS_POS_W-1:0] emu_q;
   logic [EEIS_POS_W-1:0] emu_d;
   logic [7:0] gap_q;
   logic step_q;
   logic dir_q;
   logic [2:0] pins_q;

   wire logic need_up = target_q > emu_q;
   wire logic need_dn = target_q < emu_q;
   // Steps are spaced so each step pulse has a low phase before the next
   wire logic may_step = is_out && (gap_q == 8'h0) && (need_up || need_dn);

   always_comb begin
      emu_d = emu_q;
      if (!is_out) begin
         emu_d = target_q;
      end else if (may_step && need_up) begin
         emu_d = emu_q + 48'h1;
      end else if (may_step) begin
         emu_d = emu_q - 48'h1;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         target_q <= '0;
         emu_q <= '0;
         gap_q <= 8'h0;
         step_q <= 1'b0;
         dir_q <= 1'b0;
      end else begin
         if (primary_pos_valid) begin
            target_q <= primary_pos;
         end
         emu_q <= emu_d;
         gap_q <= may_step ? 8'(EEIS_STEP_CYC - 1) : (gap_q != 8'h0 ? gap_q - 8'h1 : 8'h0);
         step_q <= may_step;
         if (may_step) begin
            dir_q <= need_up;
         end
      end
   end

   // ----------------------------------------
   // Index placement
   // ----------------------------------------
   logic [EEIS_POS_W-1:0] prev_q;
   logic phys_q;
   logic idx_q;
   logic rev_hit;
   logic abs_hit;

   eeis_index_detect u_detect (
      .prev_pos(prev_q),
      .cur_pos(primary_pos),
      .offset(zoffset_q),
      .turn(mturn_q),
      .rev_hit(rev_hit),
      .abs_hit(abs_hit)
   );

   wire logic phys_rise = phys_index && !phys_q;
   wire logic rev_fire = primary_pos_valid && is_rev && rev_hit;
   wire logic abs_fire = primary_pos_valid && is_abs && abs_hit;
   wire logic pass_fire = is_pass && phys_rise;
   // Modes are disjoint, so a crossing yields one pulse at most
   wire logic idx_d = rev_fire || abs_fire || pass_fire;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         prev_q <= '0;
         phys_q <= 1'b0;
         idx_q <= 1'b0;
         zcnt_q <= 16'h0;
      end else begin
         if (primary_pos_valid) begin
            prev_q <= primary_pos;
         end
         phys_q <= phys_index;
         idx_q <= idx_d;
         if (idx_d) begin
            zcnt_q <= zcnt_q + 16'h1;
         end
      end
   end

   // ----------------------------------------
   // Pin drivers
   // ----------------------------------------
   logic [2:0] pins_d;

   always_comb begin
      case (fmt)
         EEIS_FMT_STEP: pins_d = {idx_d, dir_q, step_q};
         EEIS_FMT_UPDN: pins_d = {idx_d, step_q && !dir_q, step_q && dir_q};
         default: pins_d = {idx_d, emu_q[1] ^ emu_q[0], emu_q[1]};
      endcase
      if (is_gpio) begin
         pins_d = gpio_out_q;
      end else if (!is_out) begin
         pins_d = 3'h0;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pins_q <= 3'h0;
      end else begin
         pins_q <= pins_d;
      end
   end

   assign pin_out = pins_q;
   // Input and tertiary modes leave all lines undriven
   assign pin_oe_n = is_out ? 3'h0 : (is_gpio ? ~gpio_drv_q : 3'h7);

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   wire logic [31:0] status = {zcnt_q, 12'h0, need_up || need_dn, pin_in};
   wire logic [31:0] rd_mux = sel_mode ? {28'h0, mode_q} :
                              sel_zoff ? {16'h0, zoffset_q} :
                              sel_turn ? mturn_q :
                              sel_fb ? {24'h0, ter_type_q, sec_type_q} :
                              sel_gpio ? {25'h0, gpio_drv_q, 1'b0, gpio_out_q} :
                              sel_st ? status :
                              sel_pos ? emu_q[31:0] : 32'h0;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rdata_q <= 32'h0;
      end else if (reg_rd) begin
         rdata_q <= rd_mux;
      end else begin
         rdata_q <= 32'h0;
      end
   end

   assign reg_rdata = rdata_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_mode_range;
      @(posedge clk_sys) disable iff (reset) mode_q <= EEIS_MODE_MAX;
   endproperty
   a_mode_range: assert property (p_mode_range) else $error("mode out of range");

   property p_mode_write;
      @(posedge clk_sys) disable iff (reset)
         reg_wr && sel_mode && mode_ok |=> mode_q == $past(reg_wdata[3:0]);
   endproperty
   a_mode_write: assert property (p_mode_write) else $error("mode write lost");

   property p_rev_cause;
      @(posedge clk_sys) disable iff (reset)
         idx_q && $past(is_rev) |-> $past(primary_pos_valid && rev_hit);
   endproperty
   a_rev_cause: assert property (p_rev_cause) else $error("index without rev crossing");

   property p_abs_fire;
      @(posedge clk_sys) disable iff (reset)
         primary_pos_valid && is_abs && (prev_q < {mturn_q, zoffset_q})
         && ({mturn_q, zoffset_q} <= primary_pos) |=> idx_q;
   endproperty
   a_abs_fire: assert property (p_abs_fire) else $error("absolute index missed");

   property p_pass_fire;
      @(posedge clk_sys) disable iff (reset)
         is_pass && phys_index && !phys_q |=> idx_q ##1 !idx_q;
   endproperty
   a_pass_fire: assert property (p_pass_fire) else $error("pass index wrong");

   property p_no_idx;
      @(posedge clk_sys) disable iff (reset)
         !$past(is_out) |-> !idx_q;
   endproperty
   a_no_idx: assert property (p_no_idx) else $error("index in non-output mode");

   property p_input_release;
      @(posedge clk_sys) disable iff (reset)
         (encoder_input_active || tertiary_input_active) |-> pin_oe_n == 3'h7;
   endproperty
   a_input_release: assert property (p_input_release) else $error("input driven");

   property p_gpio_pins;
      @(posedge clk_sys) disable iff (reset)
         is_gpio && $past(is_gpio) |-> pin_out == $past(gpio_out_q);
   endproperty
   a_gpio_pins: assert property (p_gpio_pins) else $error("gpio output wrong");

   property p_step_gap;
      @(posedge clk_sys) disable iff (reset)
         step_q |=> !step_q;
   endproperty
   a_step_gap: assert property (p_step_gap) else $error("step pulses adjacent");

   property p_abs_cause;
      @(posedge clk_sys) disable iff (reset)
         idx_q && $past(is_abs) |-> $past(primary_pos_valid && abs_hit);
   endproperty
   a_abs_cause: assert property (p_abs_cause) else $error("index without abs crossing");

   property p_pass_cause;
      @(posedge clk_sys) disable iff (reset)
         idx_q && $past(is_pass) |-> $past(phys_rise);
   endproperty
   a_pass_cause: assert property (p_pass_cause) else $error("index without phys edge");

   // The follower moves one count per decision, in the direction of the target
   property p_follow_step;
      @(posedge clk_sys) disable iff (reset)
         $past(may_step)
         |-> emu_q == ($past(need_up) ? $past(emu_q) + 48'h1 : $past(emu_q) - 48'h1);
   endproperty
   a_follow_step: assert property (p_follow_step) else $error("follower step wrong");

   // A and B never change together, so the counter cannot lose a count
   property p_quad_gray;
      @(posedge clk_sys) disable iff (reset)
         $past(is_out && (fmt == EEIS_FMT_QUAD))
         && $past(is_out && (fmt == EEIS_FMT_QUAD), 2)
         |-> $countones(pin_out[1:0] ^ $past(pin_out[1:0])) <= 1;
   endproperty
   a_quad_gray: assert property (p_quad_gray) else $error("quadrature jump");

   property p_step_dir;
      @(posedge clk_sys) disable iff (reset)
         $past(may_step && (fmt == EEIS_FMT_STEP), 2)
         && $past(is_out && (fmt == EEIS_FMT_STEP))
         |-> pin_out[0] && (pin_out[1] == $past(need_up, 2));
   endproperty
   a_step_dir: assert property (p_step_dir) else $error("step or direction wrong");

   property p_updn_line;
      @(posedge clk_sys) disable iff (reset)
         $past(may_step && (fmt == EEIS_FMT_UPDN), 2)
         && $past(is_out && (fmt == EEIS_FMT_UPDN))
         |-> pin_out[1:0] == ($past(need_up, 2) ? 2'b01 : 2'b10);
   endproperty
   a_updn_line: assert property (p_updn_line) else $error("up or down line wrong");

endmodule

// *** test/eeis_ctrl_model.sv ***
// Model of the motion controller that listens to the emulated encoder lines
`timescale 1ns/1ps
module eeis_ctrl_model (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [2:0] pin_out,
   input wire logic [2:0] pin_oe_n,
   output logic [2:0] pin_in,
   output logic [15:0] z_count,
   output logic [15:0] quad_count,
   output logic [15:0] step_count,
   output logic [15:0] updn_count
);
   logic [2:0] idle_q;
   logic z_q;
   logic [1:0] ph_q;
   logic [1:0] ab_q;
   // Quadrature phase rebuilt from the lines: A is the high bit, A xor B the low bit
   wire logic [1:0] ph = {pin_out[0], pin_out[0] ^ pin_out[1]};
   wire logic [1:0] ph_diff = ph - ph_q;
   wire logic drv = !pin_oe_n[0];
   wire logic a_rise = drv && pin_out[0] && !ab_q[0];
   wire logic b_rise = drv && pin_out[1] && !ab_q[1];

   // Released lines toggle every cycle so a stale level can never pass for a driven one
   assign pin_in = (pin_out & ~pin_oe_n) | (idle_q & pin_oe_n);

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         idle_q <= 3'h5;
         z_q <= 1'b0;
         z_count <= 16'h0;
         ph_q <= 2'h0;
         ab_q <= 2'h0;
         quad_count <= 16'h0;
         step_count <= 16'h0;
         updn_count <= 16'h0;
      end else begin
         idle_q <= ~idle_q;
         ph_q <= ph;
         ab_q <= pin_out[1:0];
         if (drv && (ph_diff == 2'h1)) begin
            quad_count <= quad_count + 16'h1;
         end else if (drv && (ph_diff == 2'h3)) begin
            quad_count <= quad_count - 16'h1;
         end
         if (a_rise) begin
            step_count <= pin_out[1] ? step_count + 16'h1 : step_count - 16'h1;
         end
         if (a_rise) begin
            updn_count <= updn_count + 16'h1;
         end else if (b_rise) begin
            updn_count <= updn_count - 16'h1;
         end
         z_q <= pin_out[2] & ~pin_oe_n[2];
         if (pin_out[2] && !pin_oe_n[2] && !z_q) begin
            z_count <= z_count + 16'h1;
         end
      end
   end
endmodule

// *** test/eeis_tb.sv ***
// Self-checking testbench for the emulated encoder index block
`timescale 1ns/1ps
module eeis_tb;
   import eeis_pkg::*;
   logic clk_sys;
   logic reset;
   logic [EEIS_AW-1:0] reg_addr;
   logic [EEIS_DW-1:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [EEIS_DW-1:0] reg_rdata;
   logic [EEIS_POS_W-1:0] primary_pos;
   logic primary_pos_valid;
   logic phys_index;
   logic [2:0] pin_in;
   logic [2:0] pin_out;
   logic [2:0] pin_oe_n;
   logic [3:0] sec_type;
   logic [3:0] ter_type;
   logic enc_act;
   logic ter_act;
   logic [15:0] z_count;
   logic [15:0] quad_count;
   logic [15:0] step_count;
   logic [15:0] updn_count;
   logic [15:0] cnt0;
   logic [15:0] cnt1;
   logic [3:0] em [6] = '{4'h1, 4'hc, 4'h6, 4'hd, 4'h8, 4'he};
   int n_fail;
   int checks_done;
   int seed;
   int d;
   logic [3:0] mode_m;
   logic [15:0] off_m;
   logic [31:0] turn_m;
   logic [47:0] prev_m;
   logic [15:0] n_idx;
   logic [31:0] rd;
   logic [3:0] rm [6] = '{4'h1, 4'h2, 4'h6, 4'h7, 4'h8, 4'h9};

   eeis_top i_eeis_top (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .primary_pos(primary_pos), .primary_pos_valid(primary_pos_valid),
      .phys_index(phys_index), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .secondary_feedback_type(sec_type), .tertiary_feedback_type(ter_type),
      .encoder_input_active(enc_act), .tertiary_input_active(ter_act));

   eeis_ctrl_model i_eeis_ctrl_model (.clk_sys(clk_sys), .reset(reset), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .pin_in(pin_in), .z_count(z_count), .quad_count(quad_count),
      .step_count(step_count), .updn_count(updn_count));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] dat);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= dat;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] dat);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      dat = reg_rdata;
   endtask

   task automatic set_cfg(input logic [3:0] m, input logic [15:0] off, input logic [31:0] tn);
      wr(EEIS_OFF_ZOFFSET, 32'(off));
      wr(EEIS_OFF_MTURN, tn);
      wr(EEIS_OFF_MODE, 32'(m));
      mode_m = m;
      off_m = off;
      turn_m = tn;
      #1;
   endtask

   // Index expected for a move from p to c under the mirrored settings
   function automatic logic exp_hit(input logic [47:0] p, input logic [47:0] c);
      logic [47:0] t;
      if (mode_m inside {4'h2, 4'h7, 4'h9}) begin
         t = {turn_m, off_m};
         return (c > p) ? (p < t && t <= c) : (c <= t && t < p);
      end
      if (!(mode_m inside {4'h1, 4'h6, 4'h8})) return 1'b0;
      t = {p[47:16], off_m};
      if (c > p) begin
         if (t <= p) t = t + 48'h1_0000;
         return t <= c;
      end
      if (t >= p) t = t - 48'h1_0000;
      return (c < p) && (t >= c);
   endfunction

   task automatic step(input logic [47:0] c);
      logic e;
      e = exp_hit(prev_m, c);
      @(posedge clk_sys);
      primary_pos <= c;
      primary_pos_valid <= 1'b1;
      @(posedge clk_sys);
      primary_pos_valid <= 1'b0;
      #1;
      chk(32'(pin_out[2]), 32'(e));
      prev_m = c;
      n_idx = n_idx + 16'(e);
   endtask

   task automatic zpass();
      logic e;
      e = mode_m inside {4'hc, 4'hd, 4'he};
      @(posedge clk_sys);
      phys_index <= 1'b1;
      @(posedge clk_sys);
      phys_index <= 1'b0;
      #1;
      chk(32'(pin_out[2]), 32'(e));
      n_idx = n_idx + 16'(e);
   endtask

   // Counter of the controller that decodes the line format of mode m, for modes 1, 6, 8, 12, 13 and 14
   function automatic logic [15:0] fmt_count(input logic [3:0] m);
      if (m inside {4'h6, 4'hd}) return step_count;
      if (m inside {4'h8, 4'he}) return updn_count;
      return quad_count;
   endfunction

   task automatic print_verdict();
      $display("TB: checks_done=%0d n_fail=%0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Clock, watchdog, sequence
   // ----------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   initial begin
      #200000;
      n_fail++;
      print_verdict();
   end

   initial begin
      seed = 61034;
      n_fail = 0;
      checks_done = 0;
      reset = 1'b1;
      {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
      {primary_pos, primary_pos_valid, phys_index} = '0;
      {mode_m, off_m, turn_m, prev_m, n_idx} = '0;
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
      #1;
      chk(32'(pin_oe_n), 32'h7);
      chk(32'(enc_act), 32'h1);
      rd_reg(EEIS_OFF_MODE, rd);
      chk(rd, 32'h0);
      for (int m = 0; m < 15; m++) begin
         set_cfg(m[3:0], 16'h0000, 32'h0);
         chk(32'(pin_oe_n), (m inside {1, 2, 6, 7, 8, 9, 12, 13, 14}) ? 0 : 7);
         chk(32'(enc_act), 32'(m inside {0, 3, 4, 5}));
         chk(32'(ter_act), 32'(m == 11));
         step(prev_m + 48'h0_c000);
         zpass();
      end
      wr(EEIS_OFF_MODE, 32'hf);
      rd_reg(EEIS_OFF_MODE, rd);
      chk(rd, 32'he);
      wr(EEIS_OFF_FBTYPE, 32'h53);
      repeat (2) @(posedge clk_sys);
      #1;
      chk(32'(sec_type), 32'h3);
      chk(32'(ter_type), 32'h5);
      rd_reg(8'h40, rd);
      chk(rd, 32'h0);
      $display("TB: modes and registers done");
      set_cfg(4'h0, 16'h8000, 32'h0);
      step({32'd3, 16'h7ff0});
      set_cfg(4'h1, 16'h8000, 32'h0);
      step({32'd3, 16'h8010});
      step({32'd4, 16'h8000});
      step({32'd4, 16'h7000});
      step({32'd3, 16'hf000});
      step({32'd3, 16'h7fff});
      set_cfg(4'h0, 16'h0010, 32'hffff_fffe);
      step({32'hffff_fffd, 16'hfff0});
      set_cfg(4'h2, 16'h0010, 32'hffff_fffe);
      rd_reg(EEIS_OFF_MTURN, rd);
      chk(rd, 32'hffff_fffe);
      step({32'hffff_fffe, 16'h0020});
      step({32'hffff_ffff, 16'h0020});
      step({32'hffff_fffe, 16'h0000});
      zpass();
      $display("TB: directed index done");
      set_cfg(4'h0, 16'h0, 32'h0);
      step({32'd100, 16'h0});
      for (int r = 0; r < 6; r++) begin
         set_cfg(rm[r], 16'($random(seed)), prev_m[47:16] + 32'(r % 2));
         for (int i = 0; i < 60; i++) begin
            d = $random(seed) % 20000;
            step(prev_m + 48'(d));
            if (i % 15 == 0) zpass();
         end
      end
      set_cfg(4'hc, 16'h0, 32'h0);
      zpass();
      rd_reg(EEIS_OFF_STATUS, rd);
      chk(32'(rd[31:16]), 32'(n_idx));
      chk(32'(z_count), 32'(n_idx));
      $display("TB: random index done");
      for (int k = 0; k < 6; k++) begin
         set_cfg(4'h0, 16'h0, 32'h0);
         step({32'd200, 16'h1000});
         set_cfg(em[k], 16'h0, 32'h0);
         cnt0 = fmt_count(em[k]);
         d = $random(seed) % 40;
         step(prev_m + 48'(d));
         repeat (88) @(posedge clk_sys);
         #1;
         cnt1 = fmt_count(em[k]) - cnt0;
         chk(32'(cnt1), {16'h0, 16'(d)});
         rd_reg(EEIS_OFF_EMUPOS, rd);
         chk(rd, prev_m[31:0]);
         rd_reg(EEIS_OFF_STATUS, rd);
         chk(32'(rd[3]), 32'h0);
      end
      $display("TB: emulated pulses done");
      set_cfg(4'ha, 16'h0, 32'h0);
      wr(EEIS_OFF_GPIO, 32'h75);
      repeat (2) @(posedge clk_sys);
      #1;
      chk(32'(pin_oe_n), 32'h0);
      chk(32'(pin_out), 32'h5);
      rd_reg(EEIS_OFF_STATUS, rd);
      chk(32'(rd[2:0]), 32'h5);
      $display("TB: general purpose lines done");
      print_verdict();
   end
endmodule
